// *** rtl/ctta_top.sv ***
// How it works
// R1: discharge, then loop charge..measure until threshold
// R2: discharge drives channel and capacitor low
// R3: charge drives channel high, capacitor floats
// R4: transfer floats both, switches closed
// R5: dead times and measure: all open, float
// R6: capacitor high in measure ends acquisition
// R7: result is the transfer count
// R8: each group up to seven pins
// R9: software enables one capacitor pin per group
// R10: groups run in parallel, channels sequential
// R11: several channels per group only specially
// R12: software mode toggles pins by itself
// R13: pulse generator drives pin sequence, 250 kHz
// R14: counter captures on any group end
// R15: capture flag, software clears before reading
// R16: software hands switches to pulse generator
// R17: software marks capacitor pins first
// R18: counter enabled first, pulse generator last
// R19: software XORs mask with pin inputs
// R20: mask write blocks finished, restarts generator
// R21: counter starts from zero each acquisition
`timescale 1ns/10ps
module ctta_top
   import ctta_pkg::*;
#(
   parameter int GROUPS = 2,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // analog group pins, seven per group
   input wire logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_I,
   output logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_O,
   output logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_OE,
   output logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_SW,
   output logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_HYST_OFF,
   // compare outputs of the pulse generator
   output logic FIRST_COMPARE_OUTPUT,
   output logic SECOND_COMPARE_OUTPUT
);
   localparam int NP = GROUPS * CTTA_PIN_NUM;

   // ***************************************************
   // register map
   // ***************************************************
   // 0x00 control: bit 0 counter enable, bit 1 pulse generator enable,
   //      bit 2 software owns the pins and the sequencer stays idle
   // 0x04 status: bit 0 capture flag, write one to clear; bit 1 busy
   // 0x08 captured transfer count, read only
   // 0x0c sample capacitor pins, one bit per group pin
   // 0x10 channel enable, one bit per group pin
   // 0x14 channel mask; a write also restarts the sequence at discharge
   // 0x18 finished channels, read only; a mask write of one clears a bit
   // unmapped words read zero and ignore writes; there is no error response
   // group g owns pin bits 7g to 7g+6; bits above the pins read zero
   //
   // the bus answers with one wait state: the access edge performs the
   // transfer and raises ready, the next edge completes it
   //
   // timing: every state but idle lasts CTTA_STATE_CYC clocks; eight slots of the
   // pulse period are budgeted and seven used, so a loop of charge to measure
   // takes five slots; a limitation is that the pulse rate is fixed by the
   // package constants, not programmable
   //
   // the sequencer stops after an end of acquisition and waits for software:
   // a mask write or a fresh enable of the pulse generator starts it again,
   // so a finished channel is never acquired twice by accident

   // ***************************************************
   // elaboration checks
   // ***************************************************
   // more than four groups would not fit the 32-bit registers
   if (GROUPS < 1 || GROUPS > 4) begin : g_bad_groups
      $error("GROUPS must be 1 to 4");
   end
   // the capture register is read over a 32-bit bus
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
      $error("CNT_W must be 2 to 32");
   end

   logic [2:0] ctrl_reg;
   logic capf_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cap_reg;
   logic [NP-1:0] scap_reg;
   logic [NP-1:0] chen_reg;
   logic [NP-1:0] mask_reg;
   logic [NP-1:0] done_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   ctta_state_e state_reg;
   logic [15:0] tick_reg;
   logic [NP-1:0] pin_o_reg, pin_oe_reg, pin_sw_reg, pin_hy_reg;
   logic oc1_reg, oc2_reg;
   logic [NP-1:0] hit;
   logic any_end;
   logic wr_acc, rd_acc, mask_wr, tick_end;
   logic stop_reg;

   // ***************************************************
   // apb decode
   // ***************************************************
   // one wait state: pready rises in the first access cycle's edge
   assign wr_acc = PSEL && PENABLE && PWRITE && !pready_reg;
   assign rd_acc = PSEL && PENABLE && !PWRITE && !pready_reg;
   assign mask_wr = wr_acc && PADDR == CTTA_MASK_OFS;
   assign tick_end = tick_reg == 16'(CTTA_STATE_CYC - 1);

   // apb handshake
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= PSEL && PENABLE && !pready_reg;
      end
   end

   // control and configuration registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ctrl_reg <= 3'h0;
         scap_reg <= '0;
         chen_reg <= '0;
         mask_reg <= '0;
      end else if (wr_acc) begin
         case (PADDR)
            CTTA_CTRL_OFS: ctrl_reg <= PWDATA[2:0];
            CTTA_SCAP_OFS: scap_reg <= PWDATA[NP-1:0]; // see R17
            CTTA_CHEN_OFS: chen_reg <= PWDATA[NP-1:0];
            CTTA_MASK_OFS: mask_reg <= PWDATA[NP-1:0]; // see R20
            default: ;
         endcase
      end
   end

   // read mux; unmapped addresses read zero with no error
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         prdata_reg <= CTTA_ZERO_RST;
      end else if (rd_acc) begin
         case (PADDR)
            CTTA_CTRL_OFS: prdata_reg <= {29'h0, ctrl_reg};
            CTTA_STAT_OFS: prdata_reg <= {30'h0, state_reg != ST_IDLE, capf_reg};
            CTTA_CAP_OFS: prdata_reg <= 32'(cap_reg); // see R7
            CTTA_SCAP_OFS: prdata_reg <= 32'(scap_reg);
            CTTA_CHEN_OFS: prdata_reg <= 32'(chen_reg);
            CTTA_MASK_OFS: prdata_reg <= 32'(mask_reg);
            CTTA_DONE_OFS: prdata_reg <= 32'(done_reg);
            default: prdata_reg <= CTTA_ZERO_RST;
         endcase
      end
   end

   // ***************************************************
   // end of acquisition detection
   // ***************************************************
   // a capacitor pin read high during measure, on an unmasked enabled channel's group
   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : g_grp
         localparam int LO = g * CTTA_PIN_NUM;
         logic [CTTA_PIN_NUM-1:0] cs, ch;
         assign cs = scap_reg[LO +: CTTA_PIN_NUM];
         assign ch = chen_reg[LO +: CTTA_PIN_NUM] & ~mask_reg[LO +: CTTA_PIN_NUM];
         // groups judged independently, in parallel; see R10 R8
         assign hit[LO +: CTTA_PIN_NUM] = (state_reg == ST_MEAS && tick_end
            && |(cs & GROUP_PIN_I[LO +: CTTA_PIN_NUM])) ? ch : '0; // see R6
      end
   endgenerate
   assign any_end = |hit;

   // finished channels, visible to software like port inputs
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         done_reg <= '0;
      end else begin
         done_reg <= (mask_wr ? done_reg & ~PWDATA[NP-1:0] : done_reg) | hit; // see R19
      end
   end

   // ***************************************************
   // pulse generator sequencer
   // ***************************************************
   // halt after an end of acquisition; without it idle would restart at once
   // and overwrite the capture before software could collect it
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         stop_reg <= 1'b0;
      end else if (!ctrl_reg[CTTA_CTRL_PULSE_EN_BIT] || ctrl_reg[CTTA_CTRL_SW_OWN_BIT]) begin
         stop_reg <= 1'b0;
      end else if (mask_wr) begin
         stop_reg <= 1'b0; // see R20
      end else if (state_reg == ST_MEAS && any_end) begin
         stop_reg <= 1'b1; // see R6
      end
   end

   // one state per tick; the pulse generator enable starts it
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_reg <= ST_IDLE;
         tick_reg <= 16'h0;
      end else if (!ctrl_reg[CTTA_CTRL_PULSE_EN_BIT] || ctrl_reg[CTTA_CTRL_SW_OWN_BIT]) begin
         state_reg <= ST_IDLE; // see R12
         tick_reg <= 16'h0;
      end else if (mask_wr) begin
         state_reg <= ST_DISCH; // see R20
         tick_reg <= 16'h0;
      end else if (state_reg == ST_IDLE) begin
         state_reg <= stop_reg ? ST_IDLE : ST_DISCH; // see R18
         tick_reg <= 16'h0;
      end else if (!tick_end) begin
         tick_reg <= tick_reg + 16'h1;
      end else begin
         tick_reg <= 16'h0;
         case (state_reg) // see R1
            ST_DISCH: state_reg <= ST_DEAD1;
            ST_DEAD1: state_reg <= ST_CHARGE;
            ST_CHARGE: state_reg <= ST_DEAD2;
            ST_DEAD2: state_reg <= ST_XFER;
            ST_XFER: state_reg <= ST_DEAD3;
            ST_DEAD3: state_reg <= ST_MEAS;
            ST_MEAS: state_reg <= any_end ? ST_IDLE : ST_CHARGE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // pin drive per state; hardware owns only enabled channels and capacitors
   // masked channels still discharge, so they start clean when unmasked;
   // they are left out of charge and transfer so they add no charge
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pin_o_reg <= '0;
         pin_oe_reg <= '0;
         pin_sw_reg <= '0;
         pin_hy_reg <= '0;
      end else begin
         pin_o_reg <= '0;
         pin_oe_reg <= '0;
         pin_sw_reg <= '0;
         pin_hy_reg <= scap_reg; // capacitor input always without hysteresis
         case (state_reg)
            ST_DISCH: pin_oe_reg <= chen_reg | scap_reg; // see R2
            ST_CHARGE: begin
               pin_o_reg <= chen_reg & ~mask_reg; // see R3
               pin_oe_reg <= chen_reg & ~mask_reg;
            end
            ST_XFER: pin_sw_reg <= (chen_reg & ~mask_reg) | scap_reg; // see R4
            default: ; // dead times and measure float; see R5
         endcase
      end
   end

   // compare outputs: first follows charge, second follows transfer
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         oc1_reg <= 1'b0;
         oc2_reg <= 1'b0;
      end else begin
         oc1_reg <= state_reg == ST_CHARGE; // see R13
         oc2_reg <= state_reg == ST_XFER;
      end
   end

   // ***************************************************
   // transfer count timer
   // ***************************************************
   // counts each completed transfer; cleared on discharge so capture equals transfers
   // the count wraps silently at CNT_W bits; software must size it for the
   // slowest electrode
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cnt_reg <= '0;
      end else if (!ctrl_reg[CTTA_CTRL_CNT_EN_BIT] || state_reg == ST_DISCH) begin
         cnt_reg <= '0; // see R21
      end else if (state_reg == ST_XFER && tick_end) begin
         cnt_reg <= cnt_reg + 1'b1; // see R7
      end
   end

   // capture on any group end; set beats a software clear of the flag
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cap_reg <= '0;
         capf_reg <= 1'b0;
      end else if (any_end && ctrl_reg[CTTA_CTRL_CNT_EN_BIT]) begin
         cap_reg <= cnt_reg; // see R14
         capf_reg <= 1'b1;
      end else if (wr_acc && PADDR == CTTA_STAT_OFS && PWDATA[CTTA_STAT_CAPF_BIT]) begin
         capf_reg <= 1'b0; // see R15
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = 1'b0;
   assign GROUP_PIN_O = pin_o_reg;
   assign GROUP_PIN_OE = pin_oe_reg;
   assign GROUP_PIN_SW = pin_sw_reg;
   assign GROUP_PIN_HYST_OFF = pin_hy_reg;
   assign FIRST_COMPARE_OUTPUT = oc1_reg;
   assign SECOND_COMPARE_OUTPUT = oc2_reg;
endmodule : ctta_top

// *** rtl/ctta_pkg.sv ***
package ctta_pkg;
   // ***************************************************
   // register offsets (byte addresses)
   // ***************************************************
   localparam logic [7:0] CTTA_CTRL_OFS = 8'h00;
   localparam logic [7:0] CTTA_STAT_OFS = 8'h04;
   localparam logic [7:0] CTTA_CAP_OFS = 8'h08;
   localparam logic [7:0] CTTA_SCAP_OFS = 8'h0c;
   localparam logic [7:0] CTTA_CHEN_OFS = 8'h10;
   localparam logic [7:0] CTTA_MASK_OFS = 8'h14;
   localparam logic [7:0] CTTA_DONE_OFS = 8'h18;
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int CTTA_CTRL_CNT_EN_BIT = 0;
   localparam int CTTA_CTRL_PULSE_EN_BIT = 1;
   localparam int CTTA_CTRL_SW_OWN_BIT = 2;
   localparam int CTTA_STAT_CAPF_BIT = 0;
   localparam int CTTA_STAT_BUSY_BIT = 1;
   // ***************************************************
   // reset values and timing
   // ***************************************************
   localparam logic [31:0] CTTA_ZERO_RST = 32'h0000_0000;
   localparam int CTTA_CLK_HZ = 100_000_000;
   localparam int CTTA_PULSE_HZ = 250_000;
   // one pulse cycle holds seven states; each state gets an eighth of it
   localparam int CTTA_STATE_CYC = CTTA_CLK_HZ / CTTA_PULSE_HZ / 8;
   localparam int CTTA_PIN_NUM = 7;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DISCH, ST_DEAD1, ST_CHARGE, ST_DEAD2, ST_XFER, ST_DEAD3, ST_MEAS
   } ctta_state_e;
endpackage : ctta_pkg

// *** sim/ctta_pads.sv ***
`timescale 1ns/10ps
module ctta_pads #(
   parameter logic [13:0] CAP = 14'h0081,
   parameter int TH0 = 3,
   parameter int TH1 = 5
) (
   // clock
   input wire logic clk,
   // pin drive from the block
   input wire logic [13:0] pin_o,
   input wire logic [13:0] pin_oe,
   input wire logic [13:0] pin_sw,
   // levels seen at the pins
   output logic [13:0] pin_i
);
   // ***************************************************
   // electrode and sampling capacitor behaviour
   // ***************************************************
   int cnt [2] = '{0, 0};
   logic [13:0] sw_d = 14'h0;
   logic [13:0] last = 14'h0;
   // seven pins a group, one capacitor pin each
   always @(posedge clk) begin
      sw_d <= pin_sw;
      last <= (pin_oe & pin_o) | (~pin_oe & last);
      for (int g = 0; g < 2; g++) begin
         if ((pin_oe & ~pin_o & CAP & (14'h7f << (7 * g))) != 14'h0) begin
            cnt[g] <= 0;
         end else if ((pin_sw & ~sw_d & CAP & (14'h7f << (7 * g))) != 14'h0) begin
            cnt[g] <= cnt[g] + 1;
         end
      end
   end
   // a floating channel shows the inverse of its last level so no stale value passes
   always_comb begin
      for (int p = 0; p < 14; p++) begin
         pin_i[p] = pin_oe[p] ? pin_o[p] :
                    CAP[p] ? (cnt[p / 7] >= ((p < 7) ? TH0 : TH1)) : ~last[p];
      end
   end
endmodule : ctta_pads

// *** sim/ctta_properties.sv ***
`timescale 1ns/10ps
module ctta_chk
   import ctta_pkg::*;
#(
   parameter int GROUPS = 2
) (
   // clock, reset and bus
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // pins and compare outputs
   input wire logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_O,
   input wire logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_OE,
   input wire logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_SW,
   input wire logic [GROUPS*CTTA_PIN_NUM-1:0] GROUP_PIN_HYST_OFF,
   input wire logic FIRST_COMPARE_OUTPUT,
   input wire logic SECOND_COMPARE_OUTPUT
);
   // ***************************************************
   // properties
   // ***************************************************
   int hi_cnt;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // length of the charge pulse, counted since a repetition would be too long
   always_ff @(posedge CLK_SYS) begin
      if (RST || !FIRST_COMPARE_OUTPUT) hi_cnt <= 0;
      else hi_cnt <= hi_cnt + 1;
   end
   a_ready_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("no answer one cycle after access");
   a_ready_pulse_once: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_never_slverr: assert property (!PSLVERR)
      else $error("error response seen");
   a_sw_floats_pin: assert property ((GROUP_PIN_SW & GROUP_PIN_OE) == '0)
      else $error("pin driven with switch closed");
   a_cap_never_high: assert property ((GROUP_PIN_OE & GROUP_PIN_O & GROUP_PIN_HYST_OFF) == '0)
      else $error("capacitor pin driven high");
   a_charge_len: assert property ($fell(FIRST_COMPARE_OUTPUT) |-> hi_cnt == CTTA_STATE_CYC)
      else $error("charge state length wrong");
   a_dead_then_xfer: assert property ($fell(FIRST_COMPARE_OUTPUT) |-> ##50 $rose(SECOND_COMPARE_OUTPUT))
      else $error("transfer not after dead time");
   a_hyst_by_write: assert property (!$stable(GROUP_PIN_HYST_OFF) |->
      $past(PSEL && PWRITE, 1) || $past(PSEL && PWRITE, 2))
      else $error("hysteresis mask changed without write");
   cover property ($rose(SECOND_COMPARE_OUTPUT));
   cover property ($fell(FIRST_COMPARE_OUTPUT));
   cover property (PREADY && PWRITE);
endmodule : ctta_chk
bind ctta_top ctta_chk #(.GROUPS(GROUPS)) ctta_chk_inst (.CLK_SYS(CLK_SYS), .RST(RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .GROUP_PIN_O(GROUP_PIN_O), .GROUP_PIN_OE(GROUP_PIN_OE), .GROUP_PIN_SW(GROUP_PIN_SW),
   .GROUP_PIN_HYST_OFF(GROUP_PIN_HYST_OFF), .FIRST_COMPARE_OUTPUT(FIRST_COMPARE_OUTPUT),
   .SECOND_COMPARE_OUTPUT(SECOND_COMPARE_OUTPUT));

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
   import ctta_pkg::*;
   // ***************************************************
   // bench
   // ***************************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, oc1, oc2;
   logic [13:0] pin_i, pin_o, pin_oe, pin_sw, pin_hy;
   int n_mismatch = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   ctta_top ctta_top_inst (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .GROUP_PIN_I(pin_i), .GROUP_PIN_O(pin_o), .GROUP_PIN_OE(pin_oe), .GROUP_PIN_SW(pin_sw),
      .GROUP_PIN_HYST_OFF(pin_hy), .FIRST_COMPARE_OUTPUT(oc1), .SECOND_COMPARE_OUTPUT(oc2));
   ctta_pads ctta_pads_inst (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_sw(pin_sw),
      .pin_i(pin_i));
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one bus transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
      if (k == 20) begin
         n_mismatch++;
         conclude();
      end
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   // poll the capture flag with a bound; long enough for five transfer loops
   task automatic wait_cap;
      int k;
      for (k = 0; k < 1000; k++) begin
         apb(1'b0, CTTA_STAT_OFS, 32'h0);
         if (rd[CTTA_STAT_CAPF_BIT] === 1'b1) break;
      end
      if (k == 1000) begin
         n_mismatch++;
         conclude();
      end
   endtask : wait_cap
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // every word reads zero after reset, the unmapped 0x1c as well
      for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0);
      apb(1'b1, CTTA_CAP_OFS, 32'hffff);
      rdc(CTTA_CAP_OFS, 32'h0);
      apb(1'b1, CTTA_SCAP_OFS, 32'h0081);
      @(posedge clk);
      chk({18'h0, pin_hy}, 32'h0081);
      apb(1'b1, CTTA_CHEN_OFS, 32'h0202);
      apb(1'b1, CTTA_CTRL_OFS, 32'h1);
      apb(1'b1, CTTA_CTRL_OFS, 32'h7);
      rdc(CTTA_STAT_OFS, 32'h0);
      apb(1'b1, CTTA_CTRL_OFS, 32'h3);
      rdc(CTTA_STAT_OFS, 32'h2);
      wait_cap();
      rdc(CTTA_CAP_OFS, 32'h3);
      rdc(CTTA_DONE_OFS, 32'h2);
      apb(1'b1, CTTA_STAT_OFS, 32'h1);
      rdc(CTTA_STAT_OFS, 32'h0);
      apb(1'b1, CTTA_MASK_OFS, 32'h2);
      wait_cap();
      rdc(CTTA_CAP_OFS, 32'h5);
      rdc(CTTA_DONE_OFS, 32'h200);
      conclude();
   end
endmodule : tb
